// ===== bench/ssrx_host_model.sv
// host model that shifts serial audio frames into the receive port
`timescale 1ns/100ps
`default_nettype none
module ssrx_host_model
(
   input  wire logic link_clk,
   output logic      frame_sync = 1'b0,
   output logic      data_a = 1'b0,
   output logic      data_b = 1'b1
);
   logic [63:0] fs_q, a_q, b_q;
   int          left = 0;
   // ====
   // bits change on the falling edge; idle data lines toggle so stale bits never match
   always @(negedge link_clk)
   begin
      if (left > 0)
      begin
         {frame_sync, data_a, data_b} <= {fs_q[left-1], a_q[left-1], b_q[left-1]};
         left <= left - 1;
      end
      else
         {data_a, data_b} <= ~{data_a, data_b};
   end
   task automatic send(input logic [63:0] f, input logic [63:0] a, input logic [63:0] b);
      {fs_q, a_q, b_q} = {f, a, b};
      left = 64;
   endtask
endmodule // ssrx_host_model
`default_nettype wire

// ===== bench/ssrx_top_properties.sv
// assertions on the ports of the secondary receive port top
`timescale 1ns/100ps
`default_nettype none
`include "ssrx_regs.svh"
module ssrx_top_properties
(
   input wire logic                    clk,
   input wire logic                    reset,
   input wire logic [`SSRX_ADDR_W-1:0] reg_addr,
   input wire logic                    reg_wr_en,
   input wire logic [`SSRX_DATA_W-1:0] reg_wdata,
   input wire logic [`SSRX_DATA_W-1:0] reg_rdata,
   input wire logic                    controller_mode,
   input wire logic [1:0]              word_length,
   input wire logic                    bit_clock_internal_sel,
   input wire logic [`SSRX_WORD_W-1:0] dac_ch1_data,
   input wire logic                    dac_ch1_valid
);
   logic [7:0] fr_r, ps_r, ch_r, rd_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // ====
   // register shadow and read path
   always_ff @(posedge clk)
   begin
      rd_r <= reset ? 8'h00 : reg_addr == 8'h26 ? fr_r : reg_addr == 8'h27 ? ps_r : reg_addr == 8'h28 ? ch_r : 8'h00;
      fr_r <= reset ? 8'h00 : reg_wr_en && reg_addr == 8'h26 ? reg_wdata : fr_r;
      ps_r <= reset ? 8'h00 : reg_wr_en && reg_addr == 8'h27 ? reg_wdata : ps_r;
      ch_r <= reset ? 8'h00 : reg_wr_en && reg_addr == 8'h28 ? {2'h0, reg_wdata[5:0]} : ch_r;
   end
   // ====
   // properties
   property p_rd; reg_rdata == rd_r; endproperty
   a_rd: assert property (p_rd) else $error("read data wrong");
   property p_rsvd; $past(reg_addr) == 8'h28 |-> reg_rdata[7:6] == 2'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
   property p_bc_on; (controller_mode && fr_r[5]) [*2] |-> bit_clock_internal_sel; endproperty
   a_bc_on: assert property (p_bc_on) else $error("bit clock select low");
   property p_bc_off; (!(controller_mode && fr_r[5])) [*2] |-> !bit_clock_internal_sel; endproperty
   a_bc_off: assert property (p_bc_off) else $error("bit clock select high");
   property p_pulse; dac_ch1_valid |=> !dac_ch1_valid; endproperty
   a_pulse: assert property (p_pulse) else $error("valid too long");
   property p_off; (!ch_r[5]) [*8] |-> !dac_ch1_valid; endproperty
   a_off: assert property (p_off) else $error("word from disabled channel");
   property p_hold; ch_r[5] && !dac_ch1_valid |-> $stable(dac_ch1_data); endproperty
   a_hold: assert property (p_hold) else $error("data moved without valid");
   property p_short; dac_ch1_valid && word_length == 2'h0 |-> dac_ch1_data[15:0] == 16'h0000; endproperty
   a_short: assert property (p_short) else $error("short word not left aligned");
   c_word: cover property (dac_ch1_valid);
   c_bc: cover property (bit_clock_internal_sel);
   c_wr: cover property (reg_wr_en && reg_addr == 8'h28);
endmodule // ssrx_top_properties
bind ssrx_top ssrx_top_properties u_props (.clk, .reset, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rdata,
   .controller_mode, .word_length, .bit_clock_internal_sel, .dac_ch1_data, .dac_ch1_valid);
`default_nettype wire

// ===== bench/ssrx_top_tb.sv
// self-checking bench for the secondary receive port
`timescale 1ns/100ps
`default_nettype none
module ssrx_top_tb;
   logic        clk = 1'b0, lclk = 1'b0, reset = 1'b1, wr_en = 1'b0, ctrl = 1'b0, use_int = 1'b0, pol = 1'b0;
   logic        bc_sel, fs, din_a, din_b, valid;
   logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
   logic [1:0]  fmt = 2'h0, wl = 2'h0;
   logic [31:0] data;
   int          fail_count = 0, samples_checked = 0;
   initial forever #25 clk = ~clk;
   initial #13 forever #40 lclk = ~lclk;
   ssrx_top dut (.clk(clk), .reset(reset), .reg_addr(addr), .reg_wr_en(wr_en), .reg_wdata(wdata),
      .reg_rdata(rdata), .controller_mode(ctrl), .serial_format(fmt), .word_length(wl),
      .bit_clock_polarity(pol), .bit_clock_internal_sel(bc_sel), .link_clk(lclk), .serial_input_pin_a(din_a),
      .serial_input_pin_b(din_b), .frame_sync_ext(use_int ? 1'b0 : fs), .frame_sync_int(use_int ? fs : 1'b0),
      .dac_ch1_data(data), .dac_ch1_valid(valid));
   ssrx_host_model host (.link_clk(lclk), .frame_sync(fs), .data_a(din_a), .data_b(din_b));
   // ====
   // access and compare tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #2;
      {addr, wdata, wr_en} = {a, d, 1'b1};
      @(posedge clk);
      #2;
      wr_en = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      addr = a;
      @(posedge clk);
      #2;
      check("reg_rdata", {24'h0, rdata}, {24'h0, exp});
   endtask
   task automatic frame(input logic [63:0] f, a, b, input logic [31:0] exp, input logic en);
      int   n;
      logic got;
      got = 1'b0;
      host.send(f, a, b);
      for (n = 0; n < 200 && got !== 1'b1; n++)
      begin
         @(posedge clk);
         #2;
         got = valid;
      end
      check("dac_ch1_valid", {31'h0, got}, {31'h0, en});
      if (en)
         check("dac_ch1_data", data, exp);
      for (n = 0; n < 200 && host.left != 0; n++)
      begin
         @(posedge clk);
         #2;
      end
      check("host_frame_done", host.left, 32'h0);
      if (got !== en)
         summarize();
   endtask
   task automatic summarize();
      if (fail_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ====
   // scenarios
   initial
   begin
      repeat (5) @(posedge clk);
      #2;
      reset = 1'b0;
      for (int i = 0; i < 4; i++)
         rd(8'(8'h26 + i), 8'h00);
      wr(8'h27, 8'hFE);
      rd(8'h27, 8'hFE);
      wr(8'h28, 8'h3F);
      rd(8'h28, 8'h3F);
      wr(8'h29, 8'h5A);
      rd(8'h29, 8'h00);
      wr(8'h26, 8'h03);
      wr(8'h27, 8'h00);
      wr(8'h28, 8'h21);
      frame(64'h8000000000000000, 64'hA5C3 << 29, ~(64'hA5C3 << 29), 32'hA5C30000, 1'b1);
      // reads give the edge select time to cross before the frame starts
      wr(8'h26, 8'h83);
      rd(8'h26, 8'h83);
      rd(8'h27, 8'h00);
      rd(8'h28, 8'h21);
      frame(64'h8000000000000000, 64'h3C96 << 29, ~(64'h3C96 << 29), 32'h3C960000, 1'b1);
      {ctrl, use_int, wl, pol} = {1'b1, 1'b1, 2'h2, 1'b1};
      wr(8'h26, 8'h7F);
      wr(8'h27, 8'h01);
      wr(8'h28, 8'h20);
      check("bit_clock_internal_sel", {31'h0, bc_sel}, 32'h1);
      frame(64'h8000000000000000, ~(64'h5A3C96 << 9), 64'h5A3C96 << 9, 32'h5A3C9600, 1'b1);
      {ctrl, use_int, wl, fmt, pol} = {1'b0, 1'b0, 2'h0, 2'h2, 1'b0};
      wr(8'h26, 8'h02);
      wr(8'h28, 8'h30);
      check("bit_clock_internal_sel", {31'h0, bc_sel}, 32'h0);
      frame(64'hFFFFFFFF00000000, ~(64'h3C5A << 14), 64'h3C5A << 14, 32'h3C5A0000, 1'b1);
      fmt = 2'h1;
      frame(64'h00000000FFFFFFFF, ~(64'h9E61 << 13), 64'h9E61 << 13, 32'h9E610000, 1'b1);
      wr(8'h28, 8'h10);
      frame(64'h00000000FFFFFFFF, 64'h0, 64'h9E61 << 13, 32'h0, 1'b0);
      // reset again in mid-run: registers and the channel-1 output return to zero
      reset = 1'b1;
      repeat (5) @(posedge clk);
      #2;
      reset = 1'b0;
      check("dac_ch1_data", data, 32'h0);
      check("dac_ch1_valid", {31'h0, valid}, 32'h0);
      rd(8'h28, 8'h00);
      rd(8'h26, 8'h00);
      summarize();
   end
endmodule // ssrx_top_tb
`default_nettype wire

// ===== rtl/ssrx_link.sv
// link-domain slot capture of the secondary receive port, clocked by the bit clock
`timescale 1ns/100ps
`default_nettype none
`include "ssrx_regs.svh"

module ssrx_link
(
   input  wire logic                    link_clk,
   input  wire logic                    reset,
   input  wire logic [`SSRX_CFG_W-1:0]  cfg,
   input  wire logic                    serial_input_pin_a,
   input  wire logic                    serial_input_pin_b,
   input  wire logic                    frame_sync_ext,
   input  wire logic                    frame_sync_int,
   output logic [`SSRX_WORD_W-1:0]      word,
   output logic                         word_toggle
);

   function automatic logic [5:0] ssrx_wl_bits(ssrx_pkg::ssrx_wl_e wl);
      unique case (wl)
         ssrx_pkg::SSRX_WL_16: ssrx_wl_bits = 6'h10;
         ssrx_pkg::SSRX_WL_20: ssrx_wl_bits = 6'h14;
         ssrx_pkg::SSRX_WL_24: ssrx_wl_bits = 6'h18;
         ssrx_pkg::SSRX_WL_32: ssrx_wl_bits = 6'h20;
      endcase
   endfunction

   // ==========================================================
   // falling-edge samples
   // ==========================================================
   logic neg_a;
   logic neg_b;
   logic neg_fse;
   logic neg_fsi;

   always_ff @(negedge link_clk)
   begin
      neg_a   <= serial_input_pin_a;
      neg_b   <= serial_input_pin_b;
      neg_fse <= frame_sync_ext;
      neg_fsi <= frame_sync_int;
   end

   // ==========================================================
   // framing and capture
   // ==========================================================
   ssrx_pkg::ssrx_link_s st_r;
   ssrx_pkg::ssrx_link_s st_nxt;

   ssrx_pkg::ssrx_cfg_s c;
   logic                use_fall;
   logic                fs;
   logic                bit_in;
   logic                start_l;
   logic                start_r;
   logic [11:0]         cur;
   logic [11:0]         target;
   logic [11:0]         wl_len;
   logic [31:0]         shifted;
   logic                two_half;

   always_comb
   begin
      st_nxt        = st_r;
      c             = ssrx_pkg::ssrx_cfg_s'(st_r.cfg_s2);
      st_nxt.cfg_s1 = cfg;
      st_nxt.cfg_s2 = st_r.cfg_s1;
      st_nxt.rst_s1 = reset;
      st_nxt.rst_s2 = st_r.rst_s1;
      // a format code outside I2S and LJ frames as TDM, with one half only
      two_half      = (c.fmt == ssrx_pkg::SSRX_FMT_I2S) || (c.fmt == ssrx_pkg::SSRX_FMT_LJ);
      use_fall      = c.polarity ^ c.edge_sel;
      if (c.ctrl_mode && c.int_fs)
         fs = use_fall ? neg_fsi : frame_sync_int;
      else
         fs = use_fall ? neg_fse : frame_sync_ext;
      if (c.pin_b)
         bit_in = use_fall ? neg_b : serial_input_pin_b;
      else
         bit_in = use_fall ? neg_a : serial_input_pin_a;
      unique case (c.fmt)
         ssrx_pkg::SSRX_FMT_I2S:
         begin
            start_l = !fs && st_r.fs_prev;
            start_r = fs && !st_r.fs_prev;
         end
         ssrx_pkg::SSRX_FMT_LJ:
         begin
            start_l = fs && !st_r.fs_prev;
            start_r = !fs && st_r.fs_prev;
         end
         default:
         begin
            start_l = fs && !st_r.fs_prev;
            start_r = 1'b0;
         end
      endcase
      cur    = (start_l || start_r) ? 12'h000 : ((&st_r.cnt) ? st_r.cnt : st_r.cnt + 12'h001);
      wl_len = {6'h00, ssrx_wl_bits(c.wl)};
      // offset shifts the MSB equally in either half; I2S adds its one-cycle delay
      target = {7'h00, c.offset} + ((c.fmt == ssrx_pkg::SSRX_FMT_I2S) ? 12'h001 : 12'h000)
             + 12'((two_half ? {2'b00, c.slot[3:0]} : {1'b0, c.slot})
             * ssrx_wl_bits(c.wl));
      shifted        = {st_r.shreg[30:0], bit_in};
      st_nxt.fs_prev = fs;
      st_nxt.cnt     = cur;
      st_nxt.half    = start_r ? 1'b1 : (start_l ? 1'b0 : st_r.half);
      if ((st_nxt.half == (two_half && c.slot[`SSRX_SLOT_HALF_BIT]))
          && cur >= target && cur < target + wl_len)
      begin
         st_nxt.shreg = shifted;
         if (cur == target + wl_len - 12'h001)
         begin
            st_nxt.word = shifted << (6'h20 - ssrx_wl_bits(c.wl));
            st_nxt.tog  = !st_r.tog;
         end
      end
      if (st_r.rst_s2)
      begin
         st_nxt.fs_prev = 1'b0;
         st_nxt.half    = 1'b0;
         st_nxt.cnt     = 12'hFFF;
         st_nxt.shreg   = 32'h0000_0000;
         st_nxt.word    = 32'h0000_0000;
         st_nxt.tog     = 1'b0;
      end
   end

   always_ff @(posedge link_clk)
   begin
      st_r <= st_nxt;
   end

   assign word        = st_r.word;
   assign word_toggle = st_r.tog;

endmodule // ssrx_link

`default_nettype wire

// ===== rtl/ssrx_pkg.sv
// types shared by the secondary receive port modules
package ssrx_pkg;

   typedef enum logic [1:0] {
      SSRX_FMT_TDM = 2'h0,
      SSRX_FMT_I2S = 2'h1,
      SSRX_FMT_LJ  = 2'h2
   } ssrx_fmt_e;

   typedef enum logic [1:0] {
      SSRX_WL_16 = 2'h0,
      SSRX_WL_20 = 2'h1,
      SSRX_WL_24 = 2'h2,
      SSRX_WL_32 = 2'h3
   } ssrx_wl_e;

   // configuration as carried into the link domain
   typedef struct packed {
      logic        polarity;
      logic        ctrl_mode;
      ssrx_fmt_e   fmt;
      ssrx_wl_e    wl;
      logic        edge_sel;
      logic        int_fs;
      logic        int_bc;
      logic [4:0]  offset;
      logic [4:0]  slot;
      logic        pin_b;
   } ssrx_cfg_s;

   typedef struct packed {
      logic [19:0] cfg_s1;
      logic [19:0] cfg_s2;
      logic        rst_s1;
      logic        rst_s2;
      logic        fs_prev;
      logic        half;
      logic [11:0] cnt;
      logic [31:0] shreg;
      logic [31:0] word;
      logic        tog;
   } ssrx_link_s;

   typedef struct packed {
      logic [7:0]  framing;
      logic [7:0]  pin_sel;
      logic [5:0]  ch1;
      logic [7:0]  rdata;
      logic        tog_s1;
      logic        tog_s2;
      logic        tog_s3;
      logic [31:0] dac_data;
      logic        dac_valid;
      logic        bc_int;
   } ssrx_top_s;

endpackage

// ===== rtl/ssrx_regs.svh
// register offsets, field positions, reset values and widths of the secondary receive port
`ifndef SSRX_REGS_SVH
`define SSRX_REGS_SVH

`define SSRX_ADDR_W            8
`define SSRX_DATA_W            8
`define SSRX_ADDR_FRAMING      8'h26
`define SSRX_ADDR_PIN_SEL      8'h27
`define SSRX_ADDR_CH1_CFG      8'h28
`define SSRX_RST_FRAMING       8'h00
`define SSRX_RST_PIN_SEL       8'h00
`define SSRX_RST_CH1_CFG       6'h00

`define SSRX_FRAMING_EDGE_BIT  7
`define SSRX_FRAMING_INTFS_BIT 6
`define SSRX_FRAMING_INTBC_BIT 5
`define SSRX_FRAMING_OFS_MSB   4
`define SSRX_FRAMING_OFS_LSB   0
`define SSRX_CH1_EN_BIT        5
`define SSRX_CH1_SLOT_MSB      4
`define SSRX_CH1_SLOT_LSB      0
`define SSRX_CH1_RW_W          6
`define SSRX_CH1_PIN_BIT       0
`define SSRX_SLOT_HALF_BIT     4

`define SSRX_CFG_W             20
`define SSRX_CNT_W             12
`define SSRX_WORD_W            32

`endif

// ===== rtl/ssrx_top.sv
// register file, controller-mode clock steering and channel-1 output of the secondary receive port
`timescale 1ns/100ps
`default_nettype none
`include "ssrx_regs.svh"

// What this block does
// - latch data on the polarity edge, or the opposite edge when edge select set
// - controller mode: frame-sync select picks internal sync when set, external when clear
// - controller mode: bit-clock select picks internal bit clock when set, else external
// - delay slot 0 MSB by offset field, 0 to 31 bit-clock cycles
// - offset applies to both data pins and both halves of two-channel formats
// - pin-select bit 0 takes channel 1 from pin A when 0, pin B when 1; bits 1-7 are stored but unused
// - channel 1 enable clear disables it; set feeds DAC channel 1
// - slot field names TDM slot 0-31, or left 0-15 / right 0-15
// - each enabled receive channel feeds the DAC channel of its own number
module ssrx_top
(
   input  wire logic                    clk,
   input  wire logic                    reset,
   input  wire logic [`SSRX_ADDR_W-1:0] reg_addr,
   input  wire logic                    reg_wr_en,
   input  wire logic [`SSRX_DATA_W-1:0] reg_wdata,
   output logic [`SSRX_DATA_W-1:0]      reg_rdata,
   input  wire logic                    controller_mode,
   input  wire logic [1:0]              serial_format,
   input  wire logic [1:0]              word_length,
   input  wire logic                    bit_clock_polarity,
   output logic                         bit_clock_internal_sel,
   input  wire logic                    link_clk,
   input  wire logic                    serial_input_pin_a,
   input  wire logic                    serial_input_pin_b,
   input  wire logic                    frame_sync_ext,
   input  wire logic                    frame_sync_int,
   output logic [`SSRX_WORD_W-1:0]      dac_ch1_data,
   output logic                         dac_ch1_valid
);

   function automatic logic [7:0] ssrx_read(logic [7:0] addr, logic [7:0] fr, logic [7:0] ps, logic [5:0] ch);
      unique case (addr)
         `SSRX_ADDR_FRAMING: ssrx_read = fr;
         `SSRX_ADDR_PIN_SEL: ssrx_read = ps;
         `SSRX_ADDR_CH1_CFG: ssrx_read = {2'b00, ch};
         default:            ssrx_read = 8'h00;
      endcase
   endfunction

   // ==========================================================
   // state
   // ==========================================================
   ssrx_pkg::ssrx_top_s st_r;
   ssrx_pkg::ssrx_top_s st_nxt;

   ssrx_pkg::ssrx_cfg_s    cfg;
   logic [`SSRX_WORD_W-1:0] link_word;
   logic                   link_tog;

   // ==========================================================
   // configuration handed to the link domain
   // ==========================================================
   always_comb
   begin
      cfg.polarity  = bit_clock_polarity;
      cfg.ctrl_mode = controller_mode;
      cfg.fmt       = ssrx_pkg::ssrx_fmt_e'(serial_format);
      cfg.wl        = ssrx_pkg::ssrx_wl_e'(word_length);
      cfg.edge_sel  = st_r.framing[`SSRX_FRAMING_EDGE_BIT];
      cfg.int_fs    = st_r.framing[`SSRX_FRAMING_INTFS_BIT];
      cfg.int_bc    = st_r.framing[`SSRX_FRAMING_INTBC_BIT];
      cfg.offset    = st_r.framing[`SSRX_FRAMING_OFS_MSB:`SSRX_FRAMING_OFS_LSB];
      cfg.slot      = st_r.ch1[`SSRX_CH1_SLOT_MSB:`SSRX_CH1_SLOT_LSB];
      cfg.pin_b     = st_r.pin_sel[`SSRX_CH1_PIN_BIT];
   end

   ssrx_link u_link
   (
      .link_clk           (link_clk),
      .reset              (reset),
      .cfg                (cfg),
      .serial_input_pin_a (serial_input_pin_a),
      .serial_input_pin_b (serial_input_pin_b),
      .frame_sync_ext     (frame_sync_ext),
      .frame_sync_int     (frame_sync_int),
      .word               (link_word),
      .word_toggle        (link_tog)
   );

   // ==========================================================
   // registers and word hand-over
   // ==========================================================
   always_comb
   begin
      st_nxt           = st_r;
      st_nxt.dac_valid = 1'b0;
      if (reg_wr_en)
      begin
         unique case (reg_addr)
            `SSRX_ADDR_FRAMING: st_nxt.framing = reg_wdata;
            `SSRX_ADDR_PIN_SEL: st_nxt.pin_sel = reg_wdata;
            // upper two bits are reserved and stay zero
            `SSRX_ADDR_CH1_CFG: st_nxt.ch1 = reg_wdata[`SSRX_CH1_RW_W-1:0];
            default:            st_nxt.framing = st_r.framing;
         endcase
      end
      st_nxt.rdata  = ssrx_read(reg_addr, st_r.framing, st_r.pin_sel, st_r.ch1);
      st_nxt.bc_int = controller_mode && st_r.framing[`SSRX_FRAMING_INTBC_BIT];
      st_nxt.tog_s1 = link_tog;
      st_nxt.tog_s2 = st_r.tog_s1;
      st_nxt.tog_s3 = st_r.tog_s2;
      // the link word is held for a whole slot after its toggle, so it is stable here
      if ((st_r.tog_s2 != st_r.tog_s3) && st_r.ch1[`SSRX_CH1_EN_BIT])
      begin
         st_nxt.dac_data  = link_word;
         st_nxt.dac_valid = 1'b1;
      end
      if (reset)
      begin
         st_nxt           = '0;
         st_nxt.framing   = `SSRX_RST_FRAMING;
         st_nxt.pin_sel   = `SSRX_RST_PIN_SEL;
         st_nxt.ch1       = `SSRX_RST_CH1_CFG;
         st_nxt.tog_s1    = st_r.tog_s1;
         st_nxt.tog_s2    = st_r.tog_s2;
         st_nxt.tog_s3    = st_r.tog_s3;
      end
   end

   always_ff @(posedge clk)
   begin
      st_r <= st_nxt;
   end

   assign reg_rdata              = st_r.rdata;
   assign bit_clock_internal_sel = st_r.bc_int;
   assign dac_ch1_data           = st_r.dac_data;
   assign dac_ch1_valid          = st_r.dac_valid;

endmodule // ssrx_top

`default_nettype wire
